// *** verilog/access_gate_pkg.sv ***
// access_gate_pkg: shared encodings, sizes and reset values for the access gate
// assumes: included ahead of every design file of the gate
package access_gate_pkg;
   // lifecycle encodings (one-hot, sampled as a stable strap)
   localparam int LC_W = 6;
   typedef enum logic [5:0] {
      secure_dev_state    = 6'b00_0001,
      nonsecure_dev_state = 6'b00_0010,
      deployed_state      = 6'b00_0100,
      debug_locked_state  = 6'b00_1000,
      boot_locked_state   = 6'b01_0000,
      other_state         = 6'b10_0000
   } lifecycle_t;

   // debug levels
   typedef enum logic [1:0] {
      no_debug_level        = 2'h0,
      nonsecure_debug_level = 2'h1,
      full_debug_level      = 2'h2
   } debug_level_t;

   // serial port command kinds
   typedef enum logic [2:0] {
      CMD_PROGRAM = 3'h0,
      CMD_ERASE   = 3'h1,
      CMD_READ    = 3'h2,
      CMD_STATE   = 3'h3,
      CMD_QUERY   = 3'h4
   } port_cmd_t;

   // monitor and attribution sizes
   localparam int ADDR_W       = 32;
   localparam int DMA_REGIONS  = 8;
   localparam int ETH_REGIONS  = 4;
   localparam int MPU_REGIONS  = 8;
   localparam int CF_REGIONS   = 3;
   localparam int CF_REGIONS_B = 6;
   localparam int DF_REGIONS   = 2;
   localparam int SR_REGIONS   = 3;
   localparam int ATTR_REGIONS = CF_REGIONS_B + DF_REGIONS + SR_REGIONS;
   localparam int PERIPH_N     = 16;
   // master ids
   localparam logic [1:0] MST_CPU = 2'h0;
   localparam logic [1:0] MST_DMA = 2'h1;
   localparam logic [1:0] MST_DTC = 2'h2;
   localparam logic [1:0] MST_ETH = 2'h3;
   // reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
endpackage : access_gate_pkg

// *** verilog/region_bus_if.sv ***
// region_bus_if: one monitor region table entry set between gate and checker
// assumes: driven by secure_access_gate, read by region_match
`timescale 1ns/1ns
interface region_bus_if #(parameter int N = 8);
   logic [31:0] base  [N];
   logic [31:0] limit [N];
   logic [N-1:0] enable;
   logic [31:0] addr;
   logic [N-1:0] hit;
   modport owner   (output base, output limit, output enable, output addr, input hit);
   modport checker_p (input base, input limit, input enable, input addr, output hit);
endinterface : region_bus_if

// *** verilog/region_match.sv ***
// region_match: compares one address against a table of regions
// assumes: region table held by the owner; pure combinational
`timescale 1ns/1ns
module region_match #(parameter int N = 8) (
   // region table and address
   region_bus_if.checker_p rb
);
   // full 32-bit inclusive window compare, no sub-window
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_cmp
         assign rb.hit[i] = rb.enable[i] && (rb.addr >= rb.base[i]) && (rb.addr <= rb.limit[i]);
      end
   endgenerate
endmodule : region_match

// *** verilog/secure_access_gate.sv ***
// secure_access_gate: lifecycle gate for the serial port, bus master monitor,
// and fixed region attribution table.
// assumes: lifecycle strap stable around reset; masters keep request up one cycle
// Notes on behaviour
// - secure dev: serial port reaches all flash
// - nonsecure dev: serial port only nonsecure flash
// - deployed and debug locked deny flash
// - denied states still take state and query
// - boot locked: serial port ignored forever
// - monitor covers the whole 32-bit space
// - eight dma regions, four ethernet regions
// - violation gives reset or nmi by choice
// - per-region security attribute on dma regions only, secure writes only
// - dma region settings always readable by anyone
// - same attribution for cpu, dma, transfer
// - three or six code, two data, three sram
// - standby, backup, peripheral attributes, some dual
// - attribution changes only in boot mode
// - attribution frozen after boot mode exit
// - eight mpu regions per security domain
// - debug level follows lifecycle state
`timescale 1ns/1ns
module secure_access_gate
   import access_gate_pkg::*;
#(
   parameter int NDMA = access_gate_pkg::DMA_REGIONS,
   parameter int NETH = access_gate_pkg::ETH_REGIONS
) (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rstn,
   // lifecycle strap and boot mode
   input  wire access_gate_pkg::lifecycle_t lifecycleIn,
   input  wire logic                        bootMode,
   // serial programming port request
   input  wire logic                        portValid,
   input  wire access_gate_pkg::port_cmd_t  portCmd,
   input  wire logic                        portSecureArea,
   output logic                             portGrant,
   output logic                             portDeny,
   output logic                             portEnabled,
   output access_gate_pkg::debug_level_t    debugLevel,
   // monitor configuration write (secure-state qualified) and unqualified read
   input  wire logic                        cfgWrite,
   input  wire logic                        cfgSecure,
   input  wire logic                        cfgEth,
   input  wire logic [3:0]                  cfgIndex,
   input  wire logic [31:0]                 cfgBase,
   input  wire logic [31:0]                 cfgLimit,
   input  wire logic                        cfgEnable,
   input  wire logic                        cfgAttrSecure,
   input  wire logic                        cfgNmiSelect,
   input  wire logic [3:0]                  rdIndex,
   output logic [31:0]                      rdBase,
   output logic [31:0]                      rdLimit,
   output logic [1:0]                       rdFlags,
   // bus master access
   input  wire logic                        mstValid,
   input  wire logic [1:0]                  mstId,
   input  wire logic [31:0]                 mstAddr,
   input  wire logic                        mstSecure,
   output logic                             resetReq,
   output logic                             nmiReq,
   output logic [31:0]                      violAddr,
   output logic [1:0]                       violId,
   output logic                             violSecure,
   // region attribution programming (boot mode only)
   input  wire logic                        attrWrite,
   input  wire logic [3:0]                  attrIndex,
   input  wire logic                        attrSecure,
   input  wire logic                        dualBank,
   input  wire logic                        attrStandby,
   input  wire logic                        attrBackup,
   input  wire logic [PERIPH_N-1:0]         attrPeriph,
   input  wire logic [PERIPH_N-1:0]         periphDual,
   output logic [ATTR_REGIONS-1:0]          regionSecure,
   output logic                             standbySecure,
   output logic                             backupSecure,
   output logic [PERIPH_N-1:0]              periphSecure,
   output logic [PERIPH_N-1:0]              periphBoth,
   output logic [4:0]                       mpuRegionCount,
   output logic                             attrLocked
);
   import access_gate_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////
   // lifecycle capture: strap caught by a clocked process while reset is held
   // the strap passes two flops; the second one freezes once reset lifts
   lifecycle_t lcSync_reg;
   lifecycle_t lcState_reg;
   always_ff @(posedge clk) begin
      lcSync_reg <= lifecycleIn;
      if (!rstn) lcState_reg <= lcSync_reg;
   end

   // decision is combinational on the captured state and the command kind
   function automatic logic flash_ok(input lifecycle_t lc, input logic sec);
      case (lc)
         secure_dev_state:    flash_ok = 1'b1;
         nonsecure_dev_state: flash_ok = !sec;
         default:             flash_ok = 1'b0;
      endcase
   endfunction : flash_ok

   wire logic isFlashCmd = (portCmd == CMD_PROGRAM) || (portCmd == CMD_ERASE) ||
                           (portCmd == CMD_READ);
   wire logic portAlive  = (lcState_reg != boot_locked_state);
   wire logic mgmtOk     = (portCmd == CMD_STATE) || (portCmd == CMD_QUERY);
   wire logic allowNow   = isFlashCmd ? flash_ok(lcState_reg, portSecureArea) : mgmtOk;
   wire logic grantNext  = portValid && portAlive && allowNow;
   wire logic denyNext   = portValid && portAlive && !allowNow;

   // debug level per lifecycle state
   debug_level_t dbgNext;
   always_comb begin
      case (lcState_reg)
         secure_dev_state:    dbgNext = full_debug_level;
         nonsecure_dev_state: dbgNext = nonsecure_debug_level;
         default:             dbgNext = no_debug_level;
      endcase
   end

   // port answer registers; boot locked state yields neither grant nor deny
   always_ff @(posedge clk) begin
      if (!rstn) begin
         portGrant   <= 1'b0;
         portDeny    <= 1'b0;
         portEnabled <= 1'b0;
         debugLevel  <= no_debug_level;
      end else begin
         portGrant   <= grantNext;
         portDeny    <= denyNext;
         portEnabled <= portAlive;
         debugLevel  <= dbgNext;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // monitor region tables
   region_bus_if #(.N(NDMA)) dmaRb ();
   region_bus_if #(.N(NETH)) ethRb ();
   logic [31:0]     dmaBase_reg  [NDMA];
   logic [31:0]     dmaLimit_reg [NDMA];
   logic [NDMA-1:0] dmaEn_reg;
   logic [NDMA-1:0] dmaSec_reg;
   logic [31:0]     ethBase_reg  [NETH];
   logic [31:0]     ethLimit_reg [NETH];
   logic [NETH-1:0] ethEn_reg;
   logic            nmiSel_reg;

   // only secure-state code may alter monitor settings and attributes
   wire logic cfgOk = cfgWrite && cfgSecure;

   genvar gi;
   generate
      for (gi = 0; gi < NDMA; gi++) begin : g_dma
         always_ff @(posedge clk) begin
            if (!rstn) begin
               dmaBase_reg[gi]  <= ADDR_RST;
               dmaLimit_reg[gi] <= ADDR_RST;
               dmaEn_reg[gi]    <= 1'b0;
               dmaSec_reg[gi]   <= 1'b0;
            end else if (cfgOk && !cfgEth && cfgIndex == 4'(gi)) begin
               dmaBase_reg[gi]  <= cfgBase;
               dmaLimit_reg[gi] <= cfgLimit;
               dmaEn_reg[gi]    <= cfgEnable;
               dmaSec_reg[gi]   <= cfgAttrSecure;
            end
         end
         assign dmaRb.base[gi]  = dmaBase_reg[gi];
         assign dmaRb.limit[gi] = dmaLimit_reg[gi];
      end
      for (gi = 0; gi < NETH; gi++) begin : g_eth
         always_ff @(posedge clk) begin
            if (!rstn) begin
               ethBase_reg[gi]  <= ADDR_RST;
               ethLimit_reg[gi] <= ADDR_RST;
               ethEn_reg[gi]    <= 1'b0;
            end else if (cfgOk && cfgEth && cfgIndex == 4'(gi)) begin
               ethBase_reg[gi]  <= cfgBase;
               ethLimit_reg[gi] <= cfgLimit;
               ethEn_reg[gi]    <= cfgEnable;
            end
         end
         assign ethRb.base[gi]  = ethBase_reg[gi];
         assign ethRb.limit[gi] = ethLimit_reg[gi];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rstn) nmiSel_reg <= 1'b0;
      else if (cfgOk) nmiSel_reg <= cfgNmiSelect;
   end

   assign dmaRb.enable = dmaEn_reg;
   assign dmaRb.addr   = mstAddr;
   assign ethRb.enable = ethEn_reg;
   assign ethRb.addr   = mstAddr;

   region_match #(.N(NDMA)) uDmaMatch (.rb(dmaRb.checker_p));
   region_match #(.N(NETH)) uEthMatch (.rb(ethRb.checker_p));

   // readback has no security qualifier on purpose: anyone may inspect
   wire logic        rdDmaOk = (32'(rdIndex) < NDMA);
   wire logic [2:0]  rdSel   = rdIndex[2:0];
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdBase  <= ADDR_RST;
         rdLimit <= ADDR_RST;
         rdFlags <= 2'h0;
      end else if (rdDmaOk) begin
         rdBase  <= dmaBase_reg[rdSel];
         rdLimit <= dmaLimit_reg[rdSel];
         rdFlags <= {dmaSec_reg[rdSel], dmaEn_reg[rdSel]};
      end else begin
         rdBase  <= ADDR_RST;
         rdLimit <= ADDR_RST;
         rdFlags <= 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // violation detection; dma and transfer masters share the eight-entry table
   wire logic dmaClass  = (mstId == MST_DMA) || (mstId == MST_DTC);
   wire logic ethClass  = (mstId == MST_ETH);
   wire logic violation = mstValid && ((dmaClass && |dmaRb.hit) || (ethClass && |ethRb.hit));

   always_ff @(posedge clk) begin
      if (!rstn) begin
         resetReq   <= 1'b0;
         nmiReq     <= 1'b0;
         violAddr   <= ADDR_RST;
         violId     <= 2'h0;
         violSecure <= 1'b0;
      end else begin
         resetReq <= violation && !nmiSel_reg;
         nmiReq   <= violation && nmiSel_reg;
         if (violation) begin
            violAddr   <= mstAddr;
            violId     <= mstId;
            violSecure <= mstSecure;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // attribution unit: writable in boot mode only, frozen on the first boot exit.
   // the freeze is sticky until reset so a later boot-mode glitch cannot reopen it.
   logic                    locked_reg;
   logic [ATTR_REGIONS-1:0] regSec_reg;
   logic                    bootSync1_reg;
   logic                    bootSync2_reg;
   // boot mode is a pin: two flops, and only the second one is read below
   always_ff @(posedge clk) begin
      bootSync1_reg <= bootMode;
      bootSync2_reg <= bootSync1_reg;
   end
   wire logic attrOpen   = bootSync2_reg && !locked_reg;
   wire logic [3:0] cfMax = dualBank ? 4'(CF_REGIONS_B) : 4'(CF_REGIONS);
   // index map: code flash 0..5, data flash 6..7, sram 8..10
   wire logic idxValid  = (attrIndex < cfMax) ||
                          ((attrIndex >= 4'(CF_REGIONS_B)) && (32'(attrIndex) < ATTR_REGIONS));

   always_ff @(posedge clk) begin
      if (!rstn) begin
         locked_reg    <= 1'b0;
         regSec_reg    <= '0;
         standbySecure <= 1'b1;
         backupSecure  <= 1'b1;
         periphSecure  <= '1;
         periphBoth    <= '0;
      end else begin
         if (!bootSync2_reg) locked_reg <= 1'b1;
         if (attrOpen && attrWrite) begin
            if (idxValid) regSec_reg[attrIndex] <= attrSecure;
            standbySecure <= attrStandby;
            backupSecure  <= attrBackup;
            periphSecure  <= attrPeriph;
            periphBoth    <= periphDual;
         end
      end
   end

   // one table serves cpu, dma and transfer masters alike
   always_ff @(posedge clk) begin
      if (!rstn) begin
         regionSecure   <= '0;
         attrLocked     <= 1'b0;
         mpuRegionCount <= 5'h00;
      end else begin
         regionSecure   <= regSec_reg;
         attrLocked     <= locked_reg;
         mpuRegionCount <= 5'(2 * MPU_REGIONS);
      end
   end
endmodule : secure_access_gate

// *** testbench/secure_access_gate_checker.sv ***
// secure_access_gate_checker: port answer, monitor pulse and attribution checks
// assumes: bound to secure_access_gate; lifecycle strap held steady after reset
`timescale 1ns/1ns
module secure_access_gate_checker
   import access_gate_pkg::*;
(
   // clock and reset
   input wire logic                            clk,
   input wire logic                            rstn,
   // serial port side
   input wire access_gate_pkg::lifecycle_t     lifecycleIn,
   input wire logic                            bootMode,
   input wire logic                            portValid,
   input wire access_gate_pkg::port_cmd_t      portCmd,
   input wire logic                            portSecureArea,
   input wire logic                            portGrant,
   input wire logic                            portDeny,
   input wire access_gate_pkg::debug_level_t   debugLevel,
   // bus master monitor
   input wire logic                            mstValid,
   input wire logic [1:0]                      mstId,
   input wire logic [31:0]                     mstAddr,
   input wire logic                            resetReq,
   input wire logic                            nmiReq,
   input wire logic [31:0]                     violAddr,
   // attribution
   input wire logic                            attrWrite,
   input wire logic [access_gate_pkg::ATTR_REGIONS-1:0] regionSecure,
   input wire logic [4:0]                      mpuRegionCount,
   input wire logic                            attrLocked
);
   import access_gate_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////
   // request shapes: flash traffic versus state change and query traffic
   sequence flashReq;
      portValid && portCmd <= CMD_READ;
   endsequence
   sequence ctrlReq;
      portValid && (portCmd == CMD_STATE || portCmd == CMD_QUERY);
   endsequence
   // debug level the strap calls for
   debug_level_t dbgExp;
   assign dbgExp = (lifecycleIn == secure_dev_state) ? full_debug_level :
                   (lifecycleIn == nonsecure_dev_state) ? nonsecure_debug_level : no_debug_level;
   ////////////////////////////////////////////////////////////////////////////
   sd_flash_ok_a: assert property (flashReq ##0 lifecycleIn == secure_dev_state
      |=> portGrant) else $error("secure dev flash request not granted");
   ns_secure_deny_a: assert property (flashReq ##0 lifecycleIn == nonsecure_dev_state
      && portSecureArea |=> portDeny && !portGrant) else $error("secure area not refused");
   locked_flash_deny_a: assert property (flashReq ##0 (lifecycleIn == deployed_state
      || lifecycleIn == debug_locked_state) |=> portDeny) else $error("flash not denied");
   ctrl_granted_a: assert property (ctrlReq ##0 lifecycleIn != boot_locked_state
      |=> portGrant) else $error("state or query request not granted");
   boot_quiet_a: assert property (lifecycleIn == boot_locked_state
      |=> !portGrant && !portDeny) else $error("boot locked port answered");
   viol_cause_a: assert property ((resetReq || nmiReq) |-> $past(mstValid)
      && $past(mstId) != MST_CPU && violAddr == $past(mstAddr)) else $error("bad violation");
   viol_single_a: assert property (!(resetReq && nmiReq))
      else $error("reset and nmi raised together");
   // boot mode reaches the unit through two flops, so it is looked at four edges back
   attr_boot_only_a: assert property (!$stable(regionSecure) |-> $past(attrWrite, 2)
      && $past(bootMode, 4)) else $error("attribution changed outside boot write");
   attr_frozen_a: assert property ($past(attrLocked) && attrLocked
      |-> $stable(regionSecure)) else $error("attribution changed after lock");
   mpu_count_a: assert property ($past(rstn) |-> mpuRegionCount == 5'(2 * MPU_REGIONS))
      else $error("mpu region count wrong");
   debug_level_a: assert property ($past(rstn) |-> debugLevel == dbgExp)
      else $error("debug level does not follow lifecycle");
endmodule : secure_access_gate_checker

bind secure_access_gate secure_access_gate_checker chk_i (.clk, .rstn, .lifecycleIn,
   .bootMode, .portValid, .portCmd, .portSecureArea, .portGrant, .portDeny, .debugLevel,
   .mstValid, .mstId, .mstAddr, .resetReq, .nmiReq, .violAddr, .attrWrite, .regionSecure,
   .mpuRegionCount, .attrLocked);

// *** testbench/bus_master_model.sv ***
// bus_master_model: cpu, dma, transfer and ethernet masters issuing single accesses
// assumes: the bench calls access() one request at a time
`timescale 1ns/1ns
module bus_master_model (
   // clock
   input  wire logic   clk,
   // master request
   output logic        mstValid,
   output logic [1:0]  mstId,
   output logic [31:0] mstAddr,
   output logic        mstSecure
);
   // idle at time zero
   initial begin
      mstValid = 1'b0;
      {mstId, mstAddr, mstSecure} = '0;
   end
   // one access held across one rising edge; released lines show the inverse
   // so a stale address can never pass for a fresh one
   task automatic access(input logic [1:0] id, input logic [31:0] a, input logic sec);
      @(negedge clk);
      mstValid = 1'b1;
      mstId = id;
      mstAddr = a;
      mstSecure = sec;
      @(negedge clk);
      mstValid = 1'b0;
      mstId = ~id;
      mstAddr = ~a;
      mstSecure = ~sec;
   endtask : access
endmodule : bus_master_model

// *** testbench/tb.sv ***
// tb: self-checking bench for secure_access_gate
// assumes: checker bound by its own file; bus masters come from bus_master_model
`timescale 1ns/1ns
module tb;
   import access_gate_pkg::*;
   lifecycle_t   lifecycleIn;
   port_cmd_t    portCmd;
   debug_level_t debugLevel;
   logic clk, rstn, bootMode, portValid, portSecureArea, portGrant, portDeny, portEnabled;
   logic cfgWrite, cfgSecure, cfgEth, cfgEnable, cfgAttrSecure, cfgNmiSelect;
   logic mstValid, mstSecure, resetReq, nmiReq, violSecure, attrWrite, attrSecure;
   logic dualBank, attrStandby, attrBackup, standbySecure, backupSecure, attrLocked;
   logic [1:0]  mstId, violId, rdFlags;
   logic [3:0]  cfgIndex, rdIndex, attrIndex;
   logic [4:0]  mpuRegionCount;
   logic [15:0] attrPeriph, periphDual, periphSecure, periphBoth;
   logic [31:0] cfgBase, cfgLimit, rdBase, rdLimit, mstAddr, violAddr;
   logic [ATTR_REGIONS-1:0] regionSecure;
   int err_total, cmp_count;
   secure_access_gate dut (.*);
   bus_master_model   bm (.*);
   ////////////////////////////////////////////////////////////////////////////
   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // compare and report
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   // the strap is only captured while reset is low
   task automatic do_reset(input lifecycle_t lc);
      @(negedge clk);
      lifecycleIn = lc;
      rstn = 1'b0;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////////
   // every command against both area kinds in one lifecycle state
   task automatic t_port(input lifecycle_t lc);
      logic eg;
      do_reset(lc);
      @(negedge clk);
      chk("portEnabled", portEnabled, lc != boot_locked_state);
      chk("debugLevel", debugLevel, lc == secure_dev_state ? full_debug_level :
          lc == nonsecure_dev_state ? nonsecure_debug_level : no_debug_level);
      for (int c = 0; c < 6; c++) begin
         for (int s = 0; s < 2; s++) begin
            portValid = 1'b1;
            portCmd = port_cmd_t'(c[2:0]);
            portSecureArea = s[0];
            @(negedge clk);
            // the answer stands for this one cycle only
            portValid = 1'b0;
            eg = (c == 3 || c == 4) || (c < 3 && (lc == secure_dev_state ||
                 (lc == nonsecure_dev_state && s == 0)));
            if (lc == boot_locked_state)
               chk("port answer", {portGrant, portDeny}, 2'b00);
            else
               chk("port answer", {portGrant, portDeny}, {eg, !eg});
            @(negedge clk);
         end
      end
      $display("port test done in %s", lc.name());
   endtask : t_port
   // one configuration write; the nmi choice travels with every write
   task automatic cfg(input logic e, s, input logic [3:0] i, input logic [31:0] b, l,
                      input logic n);
      @(negedge clk);
      {cfgWrite, cfgSecure, cfgEth, cfgIndex, cfgBase, cfgLimit, cfgNmiSelect} = {1'b1, s, e, i, b, l, n};
      @(negedge clk);
      cfgWrite = 1'b0;
   endtask : cfg
   // one master access and the answer one cycle later
   // the pulse stands only in the cycle right after the access, so look there
   task automatic hit(input logic [1:0] id, input logic [31:0] a, input logic [1:0] rn);
      bm.access(id, a, a[0]);
      chk("reset nmi", {resetReq, nmiReq}, rn);
      if (rn != 2'b00) begin
         chk("violAddr", violAddr, a);
         chk("violId", violId, id);
         chk("violSecure", violSecure, a[0]);
      end
   endtask : hit
   task automatic t_monitor;
      do_reset(secure_dev_state);
      cfg(1'b0, 1'b0, 4'h0, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
      cfg(1'b0, 1'b1, 4'h7, 32'hFFFF_F000, 32'hFFFF_FFFF, 1'b1);
      rdIndex = 4'h7;
      @(negedge clk);
      chk("rdBase 7", rdBase, 32'hFFFF_F000);
      chk("rdLimit 7", rdLimit, 32'hFFFF_FFFF);
      chk("rdFlags 7", rdFlags, 2'b11);
      rdIndex = 4'h0;
      @(negedge clk);
      chk("rdLimit 0", rdLimit, 32'h0000_0000);
      chk("rdFlags 0", rdFlags, 2'b00);
      hit(MST_DMA, 32'hFFFF_FFFF, 2'b01);
      hit(MST_DTC, 32'hFFFF_F000, 2'b01);
      chk("violId", violId, MST_DTC);
      hit(MST_CPU, 32'hFFFF_FFFF, 2'b00);
      hit(MST_DMA, 32'hFFFF_EFFF, 2'b00);
      cfg(1'b1, 1'b1, 4'h3, 32'h0000_1000, 32'h0000_10FF, 1'b0);
      hit(MST_ETH, 32'h0000_10FF, 2'b10);
      hit(MST_ETH, 32'h0000_1100, 2'b00);
      hit(MST_DMA, 32'hFFFF_F800, 2'b10);
      $display("monitor test done");
   endtask : t_monitor
   // boot mode attribute write, result two cycles on
   task automatic awr(input logic [3:0] i);
      @(negedge clk);
      attrWrite = 1'b1;
      attrIndex = i;
      @(negedge clk);
      attrWrite = 1'b0;
      repeat (2) @(negedge clk);
   endtask : awr
   task automatic t_attr;
      do_reset(secure_dev_state);
      @(negedge clk);
      chk("attr reset", {standbySecure, backupSecure, periphSecure}, 18'h3_FFFF);
      {attrSecure, attrStandby, attrBackup, attrPeriph, periphDual} = {3'b101, 32'h00F0_0F00};
      awr(4'h8);
      chk("regionSecure", regionSecure, 11'h100);
      chk("side attrs", {standbySecure, backupSecure}, 2'b01);
      chk("periph attrs", {periphSecure, periphBoth}, 32'h00F0_0F00);
      awr(4'h4);
      chk("regionSecure", regionSecure, 11'h100);
      dualBank = 1'b1;
      awr(4'h4);
      awr(4'hA);
      chk("regionSecure", regionSecure, 11'h510);
      // boot exit passes two flops, one lock flop and one output flop
      bootMode = 1'b0;
      repeat (4) @(negedge clk);
      chk("attrLocked", attrLocked, 1'b1);
      awr(4'h0);
      bootMode = 1'b1;
      awr(4'h1);
      chk("regionSecure", regionSecure, 11'h510);
      chk("mpuRegionCount", mpuRegionCount, 5'h10);
      $display("attribution test done");
   endtask : t_attr
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      lifecycle_t lcs[5];
      lcs = '{secure_dev_state, nonsecure_dev_state, deployed_state, debug_locked_state,
              boot_locked_state};
      lifecycleIn = secure_dev_state;
      portCmd = CMD_QUERY;
      {rstn, portValid, portSecureArea, cfgWrite, cfgSecure, cfgEth, cfgIndex, rdIndex} = '0;
      {cfgBase, cfgLimit, cfgNmiSelect, attrWrite, attrIndex, attrSecure, dualBank} = '0;
      {attrStandby, attrBackup, attrPeriph, periphDual} = '1;
      {bootMode, cfgEnable, cfgAttrSecure} = 3'b111;
      for (int i = 0; i < 5; i++)
         t_port(lcs[i]);
      t_monitor();
      t_attr();
      close_out();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      close_out();
   end
endmodule : tb
